// ### rtl/srr_pkg.sv
package srr_pkg;
	// clock and reference tick
	localparam int CLK_HZ = 50_000_000;
	localparam int REF_HZ = 16_000_000;
	localparam logic [6:0] TICK_INC = 7'(REF_HZ / 1_000_000);
	localparam logic [6:0] TICK_MOD = 7'(CLK_HZ / 1_000_000);
	// register byte offsets
	localparam logic [7:0] OFS_VEL = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_DIV = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_TGT = 8'h10;
	localparam logic [7:0] OFS_POS = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_LIM = 8'h1c;
	// field positions
	localparam int DIV_RATE_LSB = 0;
	localparam int DIV_RAMP_LSB = 8;
	localparam int DIV_RES_LSB = 16;
	localparam int LIM_HI_LSB = 16;
	localparam int STAT_OK_BIT = 16;
	localparam int STAT_DIR_BIT = 17;
	localparam int STAT_ST_LSB = 20;
	// value ranges and scaling
	localparam logic signed [31:0] VEL_MAX = 32'sh0000_07ff;
	localparam logic [10:0] ACC_MAX = 11'h7ff;
	localparam logic [3:0] RATE_DIV_MAX = 4'hd;
	localparam logic [3:0] RES_MAX = 4'h8;
	localparam logic [3:0] RES_RST = 4'h8;
	localparam logic [4:0] RATE_SHIFT = 5'h10;
	localparam logic [4:0] RAMP_SHIFT = 5'h0d;
	localparam logic signed [5:0] WIN_LO_OFS = 6'sh01;
	localparam logic signed [5:0] WIN_HI_OFS = 6'sh0c;
	localparam logic signed [5:0] WIN_HI_CLAMP = 6'sh0b;

	typedef enum logic [1:0]
	{
		MODE_STOP = 2'h0,
		MODE_ROTATE_CW = 2'h1,
		MODE_ROTATE_CCW = 2'h2,
		MODE_MOVE_TO_POSITION = 2'h3
	} srr_mode_t;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_FAULT = 3'b100
	} srr_state_t;

	typedef struct packed
	{
		logic wr;
		logic [7:0] addr;
	} srr_req_t;

	typedef struct packed
	{
		logic [3:0] res;
		logic [3:0] ramp_div;
		logic [3:0] rate_div;
	} srr_div_t;
endpackage : srr_pkg

// ### rtl/srr_ramp_scale.sv
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - velocity code signed, magnitude at most 2047
// - pulse rate = ref*v / 2^div / 2048 / 32
// - rate divisor 0..13, each step halves rate
// - full-step rate = pulse rate / 2^resolution
// - acceleration code unsigned 0..2047
// - slope = ref^2*a / 2^(ramp+rate+29)
// - positioning needs acceleration inside divisor window
// - upper acceleration limit clamped to 2047
// - resolution resets to setting 8
module srr_ramp_scale
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic step_out,
	output logic dir_out,
	output logic full_step_out
);
	////////////////////////////////////////////////////////////////////////
	// bus slave
	srr_pkg::srr_req_t req;
	logic [31:0] rd_mux;
	logic signed [11:0] vel_cmd;
	logic [10:0] acc_cmd;
	srr_pkg::srr_div_t div;
	srr_pkg::srr_mode_t mode;
	logic signed [31:0] tgt_pos;
	logic signed [31:0] pos;
	logic signed [11:0] vel_act;
	srr_pkg::srr_state_t state;
	logic acc_ok;
	logic [12:0] lo_lim;
	logic [10:0] hi_lim;

	wire addr_ok = hsel & htrans[1] & hready;
	wire wr_vel = req.wr & (req.addr == srr_pkg::OFS_VEL);
	wire wr_acc = req.wr & (req.addr == srr_pkg::OFS_ACC);
	wire wr_div = req.wr & (req.addr == srr_pkg::OFS_DIV);
	wire wr_ctrl = req.wr & (req.addr == srr_pkg::OFS_CTRL);
	wire wr_tgt = req.wr & (req.addr == srr_pkg::OFS_TGT);
	wire [3:0] w_rate = hwdata[srr_pkg::DIV_RATE_LSB +: 4];
	wire [3:0] w_ramp = hwdata[srr_pkg::DIV_RAMP_LSB +: 4];
	wire [3:0] w_res = hwdata[srr_pkg::DIV_RES_LSB +: 4];
	wire signed [31:0] w_vel = $signed(hwdata);
	// out-of-range velocity is saturated rather than wrapped
	wire signed [11:0] next_vel_cmd = (w_vel > srr_pkg::VEL_MAX) ? 12'(srr_pkg::VEL_MAX) :
		(w_vel < -srr_pkg::VEL_MAX) ? 12'(-srr_pkg::VEL_MAX) : w_vel[11:0];

	always_comb
	begin
		unique case (haddr[7:0])
			srr_pkg::OFS_VEL: rd_mux = 32'(vel_cmd);
			srr_pkg::OFS_ACC: rd_mux = {21'h0, acc_cmd};
			srr_pkg::OFS_DIV: rd_mux = {12'h0, div.res, 4'h0, div.ramp_div, 4'h0, div.rate_div};
			srr_pkg::OFS_CTRL: rd_mux = {30'h0, mode};
			srr_pkg::OFS_TGT: rd_mux = tgt_pos;
			srr_pkg::OFS_POS: rd_mux = pos;
			srr_pkg::OFS_STAT: rd_mux = {9'h0, state, 2'h0, dir_out, acc_ok, 4'h0, vel_act};
			srr_pkg::OFS_LIM: rd_mux = {5'h0, hi_lim, 3'h0, lo_lim};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			req <= '0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end
		else
		begin
			req <= addr_ok ? {hwrite, haddr[7:0]} : '0;
			hrdata <= (addr_ok & ~hwrite) ? rd_mux : hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vel_cmd <= 12'h000;
			acc_cmd <= 11'h000;
			div <= '{res: srr_pkg::RES_RST, ramp_div: 4'h0, rate_div: 4'h0};
			mode <= srr_pkg::MODE_STOP;
			tgt_pos <= 32'h0000_0000;
		end
		else
		begin
			if (wr_vel)
				vel_cmd <= next_vel_cmd;
			if (wr_acc)
				acc_cmd <= hwdata[10:0] & srr_pkg::ACC_MAX;
			if (wr_div && w_rate <= srr_pkg::RATE_DIV_MAX)
				div.rate_div <= w_rate;
			if (wr_div && w_ramp <= srr_pkg::RATE_DIV_MAX)
				div.ramp_div <= w_ramp;
			if (wr_div && w_res <= srr_pkg::RES_MAX)
				div.res <= w_res;
			if (wr_ctrl)
				mode <= srr_pkg::srr_mode_t'(hwdata[1:0]);
			if (wr_tgt)
				tgt_pos <= hwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reference tick: 16 of every 50 clocks, fractional so no drift
	logic [6:0] tick_acc;
	logic tick;
	wire [6:0] tick_sum = tick_acc + srr_pkg::TICK_INC;
	wire tick_wrap = tick_sum >= srr_pkg::TICK_MOD;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tick_acc <= 7'h00;
			tick <= 1'b0;
		end
		else
		begin
			tick_acc <= tick_wrap ? tick_sum - srr_pkg::TICK_MOD : tick_sum;
			tick <= tick_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// positioning window on the acceleration code
	wire signed [5:0] div_gap = $signed({2'b00, div.ramp_div}) - $signed({2'b00, div.rate_div});
	wire signed [5:0] e_lo = div_gap - srr_pkg::WIN_LO_OFS;
	wire signed [5:0] e_hi = div_gap + srr_pkg::WIN_HI_OFS;
	// a negative exponent on the lower bound rounds up to code 1
	wire [12:0] next_lo_lim = (e_lo < 0) ? 13'h0001 : 13'h0001 << e_lo[3:0];
	wire [10:0] next_hi_lim = (e_hi < 0) ? 11'h000 :
		(e_hi >= srr_pkg::WIN_HI_CLAMP) ? srr_pkg::ACC_MAX : 11'((12'h001 << e_hi[3:0]) - 12'h001);
	wire win_ok = (e_hi >= 0) && ({2'b00, acc_cmd} >= lo_lim) && (acc_cmd <= hi_lim);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lo_lim <= 13'h0001;
			hi_lim <= 11'h000;
			acc_ok <= 1'b0;
		end
		else
		begin
			lo_lim <= next_lo_lim;
			hi_lim <= next_hi_lim;
			acc_ok <= win_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode state: rotation ignores the window, positioning refuses to move outside it
	srr_pkg::srr_state_t next_state;
	wire at_target = (pos == tgt_pos);
	assign next_state = srr_pkg::srr_state_t'((mode == srr_pkg::MODE_STOP) ? srr_pkg::ST_IDLE :
		(mode == srr_pkg::MODE_MOVE_TO_POSITION && !acc_ok) ? srr_pkg::ST_FAULT :
		srr_pkg::ST_RUN);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state <= srr_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// velocity ramp: one code per 2^(ramp_div+13) acceleration-ticks gives the slope
	logic [26:0] ramp_acc;
	logic signed [11:0] vel_tgt;
	wire [10:0] vel_mag = vel_cmd[11] ? 11'(-vel_cmd) : vel_cmd[10:0];
	wire pos_mode = (mode == srr_pkg::MODE_MOVE_TO_POSITION);
	wire [26:0] ramp_thr = 27'h000_0001 << (srr_pkg::RAMP_SHIFT + 5'(div.ramp_div));
	wire [26:0] ramp_sum = ramp_acc + 27'(acc_cmd);
	wire ramp_step = tick && (vel_act != vel_tgt) && (ramp_sum >= ramp_thr);
	// positioning stops abruptly at the target; no deceleration planning here
	wire pos_halt = pos_mode && (at_target || state != srr_pkg::ST_RUN);

	always_comb
	begin
		unique case (mode)
			srr_pkg::MODE_ROTATE_CW: vel_tgt = $signed({1'b0, vel_mag});
			srr_pkg::MODE_ROTATE_CCW: vel_tgt = -$signed({1'b0, vel_mag});
			srr_pkg::MODE_MOVE_TO_POSITION:
				vel_tgt = (tgt_pos > pos) ? $signed({1'b0, vel_mag}) : -$signed({1'b0, vel_mag});
			default: vel_tgt = 12'sh000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ramp_acc <= 27'h000_0000;
			vel_act <= 12'sh000;
		end
		else if (pos_halt)
		begin
			ramp_acc <= 27'h000_0000;
			vel_act <= 12'sh000;
		end
		else if (tick && vel_act != vel_tgt)
		begin
			ramp_acc <= ramp_step ? ramp_sum - ramp_thr : ramp_sum;
			if (ramp_step)
				vel_act <= (vel_tgt > vel_act) ? vel_act + 12'sh001 : vel_act - 12'sh001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pulse generation: phase accumulator overflows at 2^(16+rate_div)
	logic [29:0] step_acc;
	logic [7:0] ustep_cnt;
	wire [10:0] act_mag = vel_act[11] ? 11'(-vel_act) : vel_act[10:0];
	wire [29:0] step_thr = 30'h0000_0001 << (srr_pkg::RATE_SHIFT + 5'(div.rate_div));
	wire [29:0] step_sum = step_acc + 30'(act_mag);
	wire step_due = tick && (act_mag != 11'h000) && (step_sum >= step_thr);
	wire [7:0] res_mask = 8'((9'h001 << div.res) - 9'h001);
	wire full_due = step_due && ((ustep_cnt & res_mask) == res_mask);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			step_acc <= 30'h0000_0000;
			ustep_cnt <= 8'h00;
			pos <= 32'sh0000_0000;
			step_out <= 1'b0;
			full_step_out <= 1'b0;
			dir_out <= 1'b0;
		end
		else
		begin
			if (tick && act_mag != 11'h000)
				step_acc <= step_due ? step_sum - step_thr : step_sum;
			if (step_due)
				ustep_cnt <= ustep_cnt + 8'h01;
			if (step_due)
				pos <= vel_act[11] ? pos - 32'sh0000_0001 : pos + 32'sh0000_0001;
			step_out <= step_due;
			full_step_out <= full_due;
			dir_out <= vel_act[11];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_step_made;
		step_due ##1 step_out;
	endsequence

	chk_vel_range: assert property (vel_cmd <= 12'sh7ff && vel_cmd >= -12'sh7ff)
		else $error("velocity code out of range");
	chk_step_tick: assert property (step_out |-> $past(tick) && $past(vel_act) != 12'sh000)
		else $error("step pulse without tick or velocity");
	chk_rate_div: assert property (div.rate_div <= 4'hd && div.ramp_div <= 4'hd)
		else $error("divisor outside 0..13");
	chk_full_step: assert property (full_step_out |-> step_out)
		else $error("full step without microstep");
	chk_step_pulse: assert property (step_due |-> s_step_made)
		else $error("step due but no pulse on the next clock");
	chk_res_max: assert property (div.res <= srr_pkg::RES_MAX)
		else $error("resolution outside 0..8");
	chk_ramp_step: assert property ($changed(vel_act) && !$past(pos_halt) |->
		$past(tick) && (vel_act - $past(vel_act) == 12'sh001 ||
		$past(vel_act) - vel_act == 12'sh001))
		else $error("ramp moved without tick or by more than one");
	// state follows mode by one clock, so the window is judged on the previous cycle
	chk_pos_window: assert property (state == srr_pkg::ST_RUN && $past(pos_mode) |->
		$past(acc_ok))
		else $error("positioning with acceleration outside window");
	chk_hi_clamp: assert property (div_gap >= 6'sh00 |=> hi_lim == 11'h7ff)
		else $error("upper limit not clamped to 2047");
	chk_res_reset: assert property ($rose(hresetn) |-> div.res == 4'h8)
		else $error("resolution not 8 after reset");
	chk_tick_gap: assert property (tick |=> !tick ##1 !tick)
		else $error("reference tick too dense");
	chk_acc_range: assert property (acc_ok |-> $past(acc_cmd) <= $past(hi_lim) &&
		{2'b00, $past(acc_cmd)} >= $past(lo_lim))
		else $error("window flag set with acceleration outside limits");
endmodule : srr_ramp_scale

// ### tb/srr_drv_model.sv
`timescale 1ns/100ps
module srr_drv_model
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic full_in,
	output int steps,
	output int fulls,
	output int pos,
	output int bad
);
	// the driver takes one microstep for every clock that shows the pulse
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			steps <= 0;
			fulls <= 0;
			pos <= 0;
			bad <= 0;
		end
		else
		begin
			if (step_in)
				steps <= steps + 1;
			if (step_in)
				pos <= dir_in ? pos - 1 : pos + 1;
			if (full_in)
				fulls <= fulls + 1;
			// a full step that is not also a microstep would desync the phase table
			if (full_in && !step_in)
				bad <= bad + 1;
		end
	end
endmodule : srr_drv_model

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout, hresp, step_out, dir_out, full_step_out;
	logic [31:0] hrdata, rd;
	int steps, fulls, pos, bad, miscompares = 0, cmp_count = 0, cyc = 0, t0, s0, f0;
	logic [31:0] lim_tab [4][3] = '{'{32'h0008_0703, 32'h0000_0008, 32'h0000_07ff},
		'{32'h0008_0303, 32'h0000_0001, 32'h0000_07ff},
		'{32'h0008_0205, 32'h0000_0001, 32'h0000_01ff},
		'{32'h0008_0d00, 32'h0000_1000, 32'h0000_07ff}};

	srr_ramp_scale i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.step_out(step_out), .dir_out(dir_out), .full_step_out(full_step_out));
	srr_drv_model i_drv (.hclk(hclk), .hresetn(hresetn), .step_in(step_out),
		.dir_in(dir_out), .full_in(full_step_out), .steps(steps), .fulls(fulls),
		.pos(pos), .bad(bad));

	initial
	begin
		forever #10 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (miscompares == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask : chk

	// model counters are plain integers, so a window check suits them
	task automatic chk_rng(input string name, input int lo, input int hi, input int got);
		cmp_count++;
		if (got < lo || got > hi)
		begin
			$display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
			miscompares++;
		end
	endtask : chk_rng

	// one single word transfer; the address phase holds until hready is seen high
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000, rd);
		chk(name, exp, rd);
		chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
	endtask : rdchk

	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			miscompares++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("div_rst", srr_pkg::OFS_DIV, 32'h0008_0000);
		rdchk("vel_rst", srr_pkg::OFS_VEL, 32'h0000_0000);
		wr(srr_pkg::OFS_DIV, 32'h0009_0e0e);
		rdchk("div_range", srr_pkg::OFS_DIV, 32'h0008_0000);
		wr(8'h40, 32'h1234_5678);
		rdchk("unmapped", 8'h40, 32'h0000_0000);
		wr(srr_pkg::OFS_VEL, 32'h0000_0bb8);
		rdchk("vel_pos", srr_pkg::OFS_VEL, 32'h0000_07ff);
		wr(srr_pkg::OFS_VEL, 32'hffff_f448);
		rdchk("vel_neg", srr_pkg::OFS_VEL, 32'hffff_f801);
		wr(srr_pkg::OFS_ACC, 32'h0000_ffff);
		rdchk("acc_mask", srr_pkg::OFS_ACC, 32'h0000_07ff);
		for (int i = 0; i < 4; i++)
		begin
			wr(srr_pkg::OFS_DIV, lim_tab[i][0]);
			rdchk("lim", srr_pkg::OFS_LIM, (lim_tab[i][2] << 16) | lim_tab[i][1]);
		end
		// smallest divisors that still cover full speed keep the ramp short
		wr(srr_pkg::OFS_DIV, 32'h0002_0000);
		wr(srr_pkg::OFS_VEL, 32'h0000_07ff);
		wr(srr_pkg::OFS_CTRL, {30'h0000_0000, srr_pkg::MODE_ROTATE_CW});
		t0 = cyc;
		rd = 32'h0000_0000;
		while (rd[11:0] !== 12'h7ff && cyc < t0 + 30000)
			ahb(1'b0, srr_pkg::OFS_STAT, 32'h0000_0000, rd);
		// 8192 ticks of 16 MHz take 25600 clocks
		chk_rng("ramp_time", 25400, 25800, cyc - t0);
		chk("dir_cw", 32'h0000_0000, {31'h0000_0000, dir_out});
		s0 = steps;
		f0 = fulls;
		repeat (10000) @(posedge hclk);
		chk_rng("rate_div0", 99, 101, steps - s0);
		chk_rng("full_rate", 24, 26, fulls - f0);
		wr(srr_pkg::OFS_DIV, 32'h0002_0001);
		s0 = steps;
		repeat (10000) @(posedge hclk);
		chk_rng("rate_div1", 49, 51, steps - s0);
		wr(srr_pkg::OFS_DIV, 32'h0002_0703);
		wr(srr_pkg::OFS_ACC, 32'h0000_0008);
		wr(srr_pkg::OFS_TGT, 32'h0010_0000);
		wr(srr_pkg::OFS_CTRL, {30'h0000_0000, srr_pkg::MODE_MOVE_TO_POSITION});
		ahb(1'b0, srr_pkg::OFS_STAT, 32'h0000_0000, rd);
		chk("acc_ok_in", 32'h0000_0001, {31'h0000_0000, rd[srr_pkg::STAT_OK_BIT]});
		wr(srr_pkg::OFS_ACC, 32'h0000_0007);
		repeat (100) @(posedge hclk);
		ahb(1'b0, srr_pkg::OFS_STAT, 32'h0000_0000, rd);
		chk("acc_ok_out", 32'h0000_0000, {31'h0000_0000, rd[srr_pkg::STAT_OK_BIT]});
		chk("fault", {29'h0000_0000, srr_pkg::ST_FAULT}, {29'h0000_0000, rd[22:20]});
		s0 = steps;
		repeat (1000) @(posedge hclk);
		chk_rng("no_steps", 0, 0, steps - s0);
		rdchk("pos", srr_pkg::OFS_POS, 32'(pos));
		chk_rng("full_pair", 0, 0, bad);
		// slow counter-clockwise run from standstill; mode first so no positive ramp sneaks in
		wr(srr_pkg::OFS_VEL, 32'h0000_0100);
		wr(srr_pkg::OFS_CTRL, {30'h0000_0000, srr_pkg::MODE_ROTATE_CCW});
		wr(srr_pkg::OFS_DIV, 32'h0002_0000);
		wr(srr_pkg::OFS_ACC, 32'h0000_07ff);
		s0 = steps;
		repeat (6000) @(posedge hclk);
		chk("dir_ccw", 32'h0000_0001, {31'h0000_0000, dir_out});
		// leftover phase from the coarser divisor may add a few early pulses
		chk_rng("ccw_steps", 4, 14, steps - s0);
		rdchk("pos_ccw", srr_pkg::OFS_POS, 32'(pos));
		end_sim();
	end
endmodule : tb
